// ---- rtl/mode_code_buffer_control.v ----
// Purpose: receive mode command buffering, control word upkeep and interrupts
// Assumes: command source gives one-cycle cmd_valid pulses while cmd_ready is high
// Notes: registers reached through AXI4-Lite via axil_reg_port
// Operation
// - mode commands use only double-buffered, indexed or simplified storage, never circular
// - simplified option off: control word double-buffer select picks double or indexed
// - simplified: info, time tag and, for mode codes 16 and up, data word go into own descriptor block
// - simplified option on: double-buffer select bit is ignored
// - interrupt handling identical with or without simplified storage
// - control word applies to receive commands with subaddress 0 or 31
// - select written while disabled: active bit not set, one buffer reused
// - host cannot write bits 8-11; device updates them only while executing
// - host writes bit 2 only while not executing; bits 3, 12-15 anytime
// - master reset clears the whole control word
// - software reset clears only accessed, buffer-B and broadcast bits
// - host read of the control word clears the accessed bit unless a message completes in that cycle while executing
// - bit 15 plus enable: interrupt when index counts from 1 to 0
// - index-zero event sets pending bit, raises irq, writes log
// - bit 14 plus enable: accessed interrupt on every receive command to subaddress 0 or 31
// - accessed bit set when message processing completes
// - double-buffered: buffer-B pointer inverts after each error-free message while busy bit 12 is clear
`include "mode_code_buffer_control_defs.vh"

module mode_code_buffer_control (
  input wire aclk, // clock, 100 MHz
  input wire aresetn, // synchronous reset, active low
  input wire [`ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output wire [1:0] s_axi_bresp, // write response
  output wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [`ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output wire [31:0] s_axi_rdata, // read data
  output wire [1:0] s_axi_rresp, // read response
  output wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire master_reset_pin_n, // master reset, active low, synchronous
  input wire cmd_valid, // command pulse
  output wire cmd_ready, // ready for a command
  input wire cmd_tr, // transmit/receive bit
  input wire [4:0] cmd_subaddr, // subaddress field
  input wire [4:0] cmd_mode_code, // mode code field
  input wire cmd_broadcast, // broadcast command
  input wire cmd_error, // message ended with error
  input wire [15:0] cmd_info, // message information word
  input wire [15:0] cmd_time_tag, // time tag word
  input wire [15:0] cmd_data, // mode data word
  output reg store_valid, // storage write pulse
  output reg [1:0] store_mode, // storage kind
  output reg store_buffer_b, // double buffer B selected
  output reg [1:0] store_word_sel, // which word is written
  output reg [4:0] store_mode_code, // mode code of the block
  output reg [15:0] store_data, // word written
  output reg log_valid, // interrupt log write pulse
  output reg [`IRQ_W-1:0] log_code, // events logged
  output wire irq // level interrupt
);

  localparam ST_IDLE = 2'h0;
  localparam ST_STORE = 2'h1;
  localparam ST_DONE = 2'h2;

  // ----------------------------------------
  // register map decode
  // ----------------------------------------
  function reg_hit;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OFF_CTRL_WORD, `OFF_TERM_CFG, `OFF_IRQ_EN, `OFF_IRQ_PEND,
        `OFF_INDEX, `OFF_LOG, `OFF_STORE_STAT: reg_hit = 1'b1;
        default: reg_hit = 1'b0;
      endcase
    end
  endfunction

  // merge low half-word bytes under strobes
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] strb;
    begin
      merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  wire wr_en;
  wire [`ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd_en;
  reg [31:0] rd_data;

  reg [15:0] cw_q;
  reg [15:0] cw_d;
  reg [`CFG_W-1:0] cfg_q;
  reg [`IRQ_W-1:0] irq_en_q;
  reg [`IRQ_W-1:0] pend_q;
  reg [`IRQ_W-1:0] pend_d;
  reg [`INDEX_W-1:0] index_q;
  reg [`LOG_CNT_W-1:0] log_cnt_q;
  reg db_act_req_q;
  reg [1:0] state_q;
  reg [1:0] word_q;
  reg [1:0] last_q;
  reg [1:0] mode_q;
  reg buf_b_q;
  reg [4:0] mc_q;
  reg broadcast_seen_flag_q;
  reg err_q;
  reg [15:0] info_q;
  reg [15:0] ttag_q;
  reg [15:0] data_q;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  axil_reg_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(reg_hit(wr_addr)),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_hit(reg_hit(s_axi_araddr))
  );

  // ----------------------------------------
  // strobes and derived controls
  // ----------------------------------------
  wire wr_cw = wr_en && (wr_addr == `OFF_CTRL_WORD);
  wire wr_cfg = wr_en && (wr_addr == `OFF_TERM_CFG);
  wire rd_cw = rd_en && (s_axi_araddr == `OFF_CTRL_WORD);
  wire sw_reset = wr_cfg && wr_strb[0] && wr_data[`CFG_SW_RESET];
  wire term_en = cfg_q[`CFG_TERM_ENABLE];
  wire term_exec = cfg_q[`CFG_TERM_EXEC];
  wire simplified = cfg_q[`CFG_SIMPLIFIED];
  wire done = (state_q == ST_DONE);
  wire [15:0] cw_wval = merge16(cw_q, wr_data[15:0], wr_strb[1:0]);
  wire [15:0] cw_wmask = `CW_HOST_ANY_MASK | (term_exec ? `CW_NONE : `CW_HOST_IDLE_MASK);
  wire [15:0] cw_host = (cw_q & ~cw_wmask) | (cw_wval & cw_wmask);
  wire idx_mode = (mode_q == `MODE_INDEXED) || (mode_q == `MODE_SIMPLIFIED);
  wire idx_zero_ev = done && idx_mode && (index_q == `INDEX_ONE);
  wire [`IRQ_W-1:0] events;
  wire match = !cmd_tr && ((cmd_subaddr == `SA_MODE_LO) || (cmd_subaddr == `SA_MODE_HI));
  wire has_data = (cmd_mode_code >= `MC_DATA_MIN);

  // index-zero event only in indexed and simplified storage, accessed event in every kind
  assign events[`IRQ_INDEX_ZERO] = idx_zero_ev && cw_q[`CW_IDXZ_EN] && irq_en_q[`IRQ_INDEX_ZERO];
  assign events[`IRQ_ACCESSED] = done && cw_q[`CW_ACC_EN] && irq_en_q[`IRQ_ACCESSED];
  assign irq = |(pend_q & irq_en_q);
  assign cmd_ready = (state_q == ST_IDLE);

  // ----------------------------------------
  // control word next value
  // ----------------------------------------
  always @* begin
    cw_d = cw_q;
    if (wr_cw) begin
      cw_d = cw_host;
    end
    if (sw_reset) begin
      cw_d = cw_d & ~`CW_SWR_CLR_MASK;
    end
    if (rd_cw) begin
      cw_d[`CW_ACCESSED] = 1'b0;
    end
    if (term_exec) begin
      if (!cw_d[`CW_DB_SEL] || cw_d[`CW_DB_STOP]) begin
        cw_d[`CW_DB_ACT] = 1'b0;
      end else if (db_act_req_q) begin
        cw_d[`CW_DB_ACT] = 1'b1;
      end
      if (done) begin
        cw_d[`CW_ACCESSED] = 1'b1;
        if (broadcast_seen_flag_q) begin
          cw_d[`CW_BC_SEEN] = 1'b1;
        end
        if (mode_q == `MODE_DOUBLE && !err_q && !cw_q[`CW_BUSY]) begin
          cw_d[`CW_BUF_B] = ~cw_q[`CW_BUF_B];
        end
      end
    end
  end

  // control word register
  always @(posedge aclk) begin
    if (!aresetn || !master_reset_pin_n) begin
      cw_q <= `CW_RESET;
    end else begin
      cw_q <= cw_d;
    end
  end

  // active-bit request only from writes made while enabled
  always @(posedge aclk) begin
    if (!aresetn || !master_reset_pin_n) begin
      db_act_req_q <= 1'b0;
    end else if (wr_cw) begin
      db_act_req_q <= term_en && cw_host[`CW_DB_SEL];
    end else if (term_exec) begin
      db_act_req_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // host registers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= {`CFG_W{1'b0}};
      irq_en_q <= {`IRQ_W{1'b0}};
    end else begin
      if (wr_cfg && wr_strb[0]) begin
        cfg_q <= wr_data[`CFG_W-1:0];
      end
      if (wr_en && wr_addr == `OFF_IRQ_EN && wr_strb[0]) begin
        irq_en_q <= wr_data[`IRQ_W-1:0];
      end
    end
  end

  // index count: host load, decrement per indexed or simplified message, holding at zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      index_q <= `INDEX_ZERO;
    end else if (wr_en && wr_addr == `OFF_INDEX && wr_strb[0]) begin
      index_q <= wr_data[`INDEX_W-1:0];
    end else if (done && idx_mode && index_q != `INDEX_ZERO) begin
      index_q <= index_q - `INDEX_ONE;
    end
  end

  // ----------------------------------------
  // pending interrupts and log
  // ----------------------------------------
  always @* begin
    pend_d = pend_q;
    if (wr_en && wr_addr == `OFF_IRQ_PEND && wr_strb[0]) begin
      pend_d = pend_d & ~wr_data[`IRQ_W-1:0];
    end
    pend_d = pend_d | events;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= {`IRQ_W{1'b0}};
      log_valid <= 1'b0;
      log_code <= {`IRQ_W{1'b0}};
      log_cnt_q <= {`LOG_CNT_W{1'b0}};
    end else begin
      pend_q <= pend_d;
      log_valid <= |events;
      if (|events) begin
        log_code <= events;
        log_cnt_q <= log_cnt_q + {{(`LOG_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    case (s_axi_araddr)
      `OFF_CTRL_WORD: rd_data = {16'h0000, cw_q};
      `OFF_TERM_CFG: rd_data = {{(32-`CFG_W){1'b0}}, cfg_q};
      `OFF_IRQ_EN: rd_data = {{(32-`IRQ_W){1'b0}}, irq_en_q};
      `OFF_IRQ_PEND: rd_data = {{(32-`IRQ_W){1'b0}}, pend_q};
      `OFF_INDEX: rd_data = {{(32-`INDEX_W){1'b0}}, index_q};
      `OFF_LOG: rd_data = {16'h0000, log_cnt_q, {(8-`IRQ_W){1'b0}}, log_code};
      `OFF_STORE_STAT: rd_data = {24'h00_0000, 1'b0, state_q, buf_b_q, 2'h0, mode_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // command sequencer and storage writes
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      word_q <= `WORD_INFO;
      last_q <= `WORD_INFO;
      mode_q <= `MODE_INDEXED;
      buf_b_q <= 1'b0;
      mc_q <= 5'h00;
      broadcast_seen_flag_q <= 1'b0;
      err_q <= 1'b0;
      info_q <= 16'h0000;
      ttag_q <= 16'h0000;
      data_q <= 16'h0000;
      store_valid <= 1'b0;
      store_mode <= `MODE_INDEXED;
      store_buffer_b <= 1'b0;
      store_word_sel <= `WORD_INFO;
      store_mode_code <= 5'h00;
      store_data <= 16'h0000;
    end else begin
      store_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid && match) begin
            mc_q <= cmd_mode_code;
            broadcast_seen_flag_q <= cmd_broadcast;
            err_q <= cmd_error;
            info_q <= cmd_info;
            ttag_q <= cmd_time_tag;
            data_q <= cmd_data;
            buf_b_q <= cw_q[`CW_BUF_B];
            last_q <= has_data ? `WORD_DATA : `WORD_TTAG;
            if (simplified) begin
              mode_q <= `MODE_SIMPLIFIED;
              word_q <= `WORD_INFO;
              state_q <= ST_STORE;
            end else begin
              if (!cw_q[`CW_DB_SEL]) begin
                mode_q <= `MODE_INDEXED;
              end else if (cw_q[`CW_DB_ACT]) begin
                mode_q <= `MODE_DOUBLE;
              end else begin
                mode_q <= `MODE_DOUBLE_HELD;
              end
              word_q <= `WORD_DATA;
              state_q <= (has_data && !cw_q[`CW_BUSY]) ? ST_STORE : ST_DONE;
            end
          end
        end
        ST_STORE: begin
          store_valid <= 1'b1;
          store_mode <= mode_q;
          store_buffer_b <= buf_b_q;
          store_word_sel <= word_q;
          store_mode_code <= mc_q;
          case (word_q)
            `WORD_INFO: store_data <= info_q;
            `WORD_TTAG: store_data <= ttag_q;
            default: store_data <= data_q;
          endcase
          if (word_q == last_q) begin
            state_q <= ST_DONE;
          end else begin
            word_q <= word_q + 2'h1;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- inc/mode_code_buffer_control_defs.vh ----
// Purpose: constants shared by the mode code buffer control block and its register port
// Assumes: 32-bit AXI4-Lite data, 8-bit byte offsets
// Notes: offsets are byte addresses, one aligned word per register
`ifndef MODE_CODE_BUFFER_CONTROL_DEFS_VH
`define MODE_CODE_BUFFER_CONTROL_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_W 8
`define OFF_CTRL_WORD 8'h00
`define OFF_TERM_CFG 8'h04
`define OFF_IRQ_EN 8'h08
`define OFF_IRQ_PEND 8'h0C
`define OFF_INDEX 8'h10
`define OFF_LOG 8'h14
`define OFF_STORE_STAT 8'h18

// ----------------------------------------
// receive mode control word fields
// ----------------------------------------
`define CW_IDXZ_EN 15
`define CW_ACC_EN 14
`define CW_BUSY 12
`define CW_ACCESSED 11
`define CW_BUF_B 10
`define CW_BC_SEEN 9
`define CW_DB_ACT 8
`define CW_DB_STOP 3
`define CW_DB_SEL 2
`define CW_RESET 16'h0000
`define CW_HOST_ANY_MASK 16'hF008
`define CW_HOST_IDLE_MASK 16'h0004
`define CW_SWR_CLR_MASK 16'h0E00
`define CW_NONE 16'h0000

// ----------------------------------------
// terminal configuration, interrupt and index fields
// ----------------------------------------
`define CFG_TERM_ENABLE 0
`define CFG_TERM_EXEC 1
`define CFG_SIMPLIFIED 2
`define CFG_SW_RESET 3
`define CFG_W 3
`define IRQ_INDEX_ZERO 0
`define IRQ_ACCESSED 1
`define IRQ_W 2
`define INDEX_W 8
`define INDEX_ONE 8'h01
`define INDEX_ZERO 8'h00
`define LOG_CNT_W 8

// ----------------------------------------
// command decode and storage encodings
// ----------------------------------------
`define SA_MODE_LO 5'h00
`define SA_MODE_HI 5'h1F
`define MC_DATA_MIN 5'h10
`define WORD_INFO 2'h0
`define WORD_TTAG 2'h1
`define WORD_DATA 2'h2
`define MODE_INDEXED 2'h0
`define MODE_DOUBLE 2'h1
`define MODE_SIMPLIFIED 2'h2
`define MODE_DOUBLE_HELD 2'h3
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ---- rtl/axil_reg_port.v ----
// Purpose: AXI4-Lite slave turning bus transfers into register strobes
// Assumes: one write and one read in flight at most
// Notes: write strobe fires in the first cycle that both address and data are held
`include "mode_code_buffer_control_defs.vh"

module axil_reg_port (
  input wire aclk, // clock
  input wire aresetn, // synchronous reset, active low
  input wire [`ADDR_W-1:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [`ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  output wire wr_en, // register write strobe
  output reg [`ADDR_W-1:0] wr_addr, // held write address
  output reg [31:0] wr_data, // held write data
  output reg [3:0] wr_strb, // held byte enables
  input wire wr_hit, // write address is mapped
  output wire rd_en, // register read strobe
  input wire [31:0] rd_data, // read data for s_axi_araddr
  input wire rd_hit // read address is mapped
);

  reg aw_hold_q;
  reg w_hold_q;

  // channel readies
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en = aw_hold_q && w_hold_q;
  assign rd_en = s_axi_arvalid && s_axi_arready;

  // write path: hold each channel, then strobe and respond
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      wr_addr <= `OFF_CTRL_WORD;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read path: data captured on the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_hit ? rd_data : 32'h0000_0000;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- dv/mcbc_chk.sv ----
// Purpose: port assertions for mode_code_buffer_control
// Assumes: one clock domain, reset aresetn active low
// Notes: bind after endmodule
`include "mode_code_buffer_control_defs.vh"
module mcbc_chk (
  input logic aclk, // clock
  input logic aresetn, // reset, active low
  input logic s_axi_bvalid, // write response valid
  input logic s_axi_bready, // write response ready
  input logic s_axi_arready, // read address ready
  input logic s_axi_rvalid, // read data valid
  input logic cmd_valid, // command pulse
  input logic cmd_ready, // command ready
  input logic cmd_tr, // t/r bit
  input logic [4:0] cmd_subaddr, // subaddress
  input logic store_valid, // store pulse
  input logic [1:0] store_mode, // storage kind
  input logic [1:0] store_word_sel, // word select
  input logic log_valid, // log pulse
  input logic [`IRQ_W-1:0] log_code // logged events
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // command acceptance and storage
  // ----------------------------------------
  // receive command to subaddress 0 or 31
  logic mode_cmd;
  assign mode_cmd = !cmd_tr && (cmd_subaddr == `SA_MODE_LO || cmd_subaddr == `SA_MODE_HI);
  property p_take; cmd_valid && cmd_ready && mode_cmd |=> !cmd_ready; endproperty
  a_take: assert property (p_take) else $error("mode command not taken");
  property p_drop; cmd_valid && cmd_ready && !mode_cmd |=> cmd_ready; endproperty
  a_drop: assert property (p_drop) else $error("foreign command taken");
  property p_busy; store_valid |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("store outside a command");
  property p_word; store_valid && store_mode != `MODE_SIMPLIFIED |-> store_word_sel == `WORD_DATA; endproperty
  a_word: assert property (p_word) else $error("buffered mode stored a non-data word");
  property p_order;
    store_valid && store_mode == `MODE_SIMPLIFIED && store_word_sel == `WORD_INFO
      |=> store_valid && store_word_sel == `WORD_TTAG;
  endproperty
  a_order: assert property (p_order) else $error("time tag not after info word");
  property p_log; log_valid |-> |log_code; endproperty
  a_log: assert property (p_log) else $error("empty log entry");
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read address taken while busy");
  c_simpl: cover property (store_valid && store_mode == `MODE_SIMPLIFIED && store_word_sel == `WORD_DATA);
  c_dbl: cover property (store_valid && store_mode == `MODE_DOUBLE);
  c_log: cover property (log_valid);
endmodule

bind mode_code_buffer_control mcbc_chk mcbc_chk_i (.*);

// ---- dv/cmd_src.sv ----
// Purpose: bus command source feeding mode commands
// Assumes: send is called only while cmd_ready is high
// Notes: payload inverted after the pulse
module cmd_src (
  input logic aclk, // clock
  input logic cmd_ready, // device can take a command
  output logic cmd_valid, // one-cycle command pulse
  output logic cmd_tr, // t/r bit
  output logic [4:0] cmd_subaddr, // subaddress
  output logic [4:0] cmd_mode_code, // mode code
  output logic cmd_broadcast, // broadcast flag
  output logic cmd_error, // error flag
  output logic [15:0] cmd_info, // info word
  output logic [15:0] cmd_time_tag, // time tag
  output logic [15:0] cmd_data // data word
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines at time zero
  initial begin
    cmd_valid = 1'h0;
    {cmd_tr, cmd_subaddr, cmd_mode_code, cmd_broadcast, cmd_error} = 13'h0;
    {cmd_info, cmd_time_tag, cmd_data} = 48'h0;
  end
  // one pulse, then inverted payload
  task send(input logic tr, input logic [4:0] sa, input logic [4:0] mc);
    cmd_valid <= 1'h1;
    cmd_tr <= tr;
    cmd_subaddr <= sa;
    cmd_mode_code <= mc;
    cmd_info <= 16'h1234;
    cmd_time_tag <= 16'h5678;
    cmd_data <= 16'h9ABC;
    @(posedge aclk);
    cmd_valid <= 1'h0;
    {cmd_info, cmd_time_tag, cmd_data} <= ~{cmd_info, cmd_time_tag, cmd_data};
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for mode_code_buffer_control
// Assumes: 100 MHz aclk, AXI4-Lite master tasks, cmd_src partner
// Notes: table rows check host write masks, hand tests follow
`include "mode_code_buffer_control_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, master_reset_pin_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0] s_axi_wstrb;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_ready, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp, store_mode, store_word_sel, log_code;
  wire [31:0] s_axi_rdata;
  wire cmd_valid, cmd_tr, cmd_broadcast, cmd_error, store_valid, store_buffer_b, log_valid;
  wire [4:0] cmd_subaddr, cmd_mode_code, store_mode_code;
  wire [15:0] cmd_info, cmd_time_tag, cmd_data, store_data;
  int errors, comparisons;
  typedef struct {logic [15:0] cfg, cw, exp;} row_t;
  // cfg, written word, read back
  row_t rows [5] = '{'{16'h0, 16'hFFFF, 16'hF00C}, '{16'h2, 16'h0, 16'h4}, '{16'h0, 16'h0, 16'h0},
    '{16'h2, 16'hFFFF, 16'hF008}, '{16'h0, 16'h0F00, 16'h0}};
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  mode_code_buffer_control mode_code_buffer_control_i (.*);
  cmd_src cmd_src_i (.*);
  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // handshakes judged mid-cycle, released after the edge that takes them
  task wr(input [7:0] a, input [15:0] d, input [1:0] er = `RESP_OKAY);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] rp;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      rp = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'h0;
      if (w_ok) s_axi_wvalid <= 1'h0;
    end while (!b_ok);
    chk({30'h0, rp}, {30'h0, er});
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task rchk(input [7:0] a, input [15:0] e, input [15:0] m = 16'hFFFF, input [1:0] er = `RESP_OKAY);
    logic ar_ok, r_ok;
    logic [1:0] rp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      rd = s_axi_rdata;
      rp = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'h0;
    end while (!r_ok);
    chk({30'h0, rp}, {30'h0, er});
    chk(rd & {16'hFFFF, m}, {16'h0, e});
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  // one command, wait for idle and flag updates
  task msg(input tr, input [4:0] sa, input [4:0] mc);
    cmd_src_i.send(tr, sa, mc);
    do @(negedge aclk); while (!cmd_ready);
    repeat (3) @(posedge aclk);
  endtask
  task tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    master_reset_pin_n = 1'h1;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(`OFF_CTRL_WORD, 16'h0);
    foreach (rows[i]) begin
      wr(`OFF_TERM_CFG, rows[i].cfg);
      wr(`OFF_CTRL_WORD, rows[i].cw);
      rchk(`OFF_CTRL_WORD, rows[i].exp);
    end
    wr(`OFF_CTRL_WORD, 16'hF00C);
    master_reset_pin_n <= 1'h0;
    @(posedge aclk);
    master_reset_pin_n <= 1'h1;
    rchk(`OFF_CTRL_WORD, 16'h0);
    // simplified storage, accessed interrupt, foreign commands
    wr(`OFF_TERM_CFG, 16'h7);
    wr(`OFF_IRQ_EN, 16'h2);
    wr(`OFF_CTRL_WORD, 16'h4000);
    msg(1'h1, 5'h00, 5'h11);
    msg(1'h0, 5'h05, 5'h11);
    rchk(`OFF_CTRL_WORD, 16'h4000);
    msg(1'h0, 5'h1F, 5'h11);
    chk({31'h0, irq}, 32'h1);
    rchk(`OFF_IRQ_PEND, 16'h2, 16'h3);
    rchk(`OFF_LOG, 16'h2, 16'h3);
    rchk(`OFF_STORE_STAT, 16'h2, 16'h3);
    rchk(`OFF_CTRL_WORD, 16'h4800);
    rchk(`OFF_CTRL_WORD, 16'h4000);
    wr(`OFF_IRQ_EN, 16'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`OFF_IRQ_EN, 16'h2);
    chk({31'h0, irq}, 32'h1);
    wr(`OFF_IRQ_PEND, 16'h2);
    chk({31'h0, irq}, 32'h0);
    // indexed storage, index counts from 1 to 0
    wr(`OFF_TERM_CFG, 16'h3);
    wr(`OFF_CTRL_WORD, 16'h8000);
    wr(`OFF_INDEX, 16'h1);
    wr(`OFF_IRQ_EN, 16'h1);
    msg(1'h0, 5'h00, 5'h11);
    chk({31'h0, irq}, 32'h1);
    rchk(`OFF_IRQ_PEND, 16'h1, 16'h3);
    rchk(`OFF_INDEX, 16'h0, 16'hFF);
    rchk(`OFF_STORE_STAT, 16'h0, 16'h3);
    wr(`OFF_IRQ_PEND, 16'h1);
    // select written while terminal disabled: one buffer reused
    wr(`OFF_TERM_CFG, 16'h0);
    wr(`OFF_CTRL_WORD, 16'h4);
    wr(`OFF_TERM_CFG, 16'h3);
    msg(1'h0, 5'h00, 5'h12);
    rchk(`OFF_CTRL_WORD, 16'h0804);
    rchk(`OFF_STORE_STAT, 16'h3, 16'h3);
    // proper double buffering, software reset in between
    wr(`OFF_TERM_CFG, 16'h1);
    wr(`OFF_CTRL_WORD, 16'h4);
    wr(`OFF_TERM_CFG, 16'h3);
    msg(1'h0, 5'h00, 5'h12);
    wr(`OFF_TERM_CFG, 16'hB);
    rchk(`OFF_CTRL_WORD, 16'h0104);
    msg(1'h0, 5'h1F, 5'h12);
    rchk(`OFF_CTRL_WORD, 16'h0D04);
    rchk(`OFF_STORE_STAT, 16'h1, 16'h3);
    wr(`OFF_TERM_CFG, 16'h7);
    msg(1'h0, 5'h00, 5'h03);
    rchk(`OFF_STORE_STAT, 16'h2, 16'h3);
    // unmapped place
    rchk(8'hFC, 16'h0, 16'hFFFF, `RESP_DECERR);
    wr(8'hFC, 16'hFFFF, `RESP_DECERR);
    tally_and_finish();
  end
  // hang guard
  initial begin
    #100us;
    errors++;
    tally_and_finish();
  end
endmodule
